// File: bwsc_checker.sv
// Purpose: Port assertions for the wait-state block
// Assumes: One clock, sync active-low reset
// Notes: Bound to bwsc_top below
`timescale 1ns/1ps
`default_nettype none
module bwsc_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic dma_req_valid,
	input wire logic dma_req_ready,
	input wire logic dma_done,
	input wire logic [3:0] dma_cycles,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_arready,
	input wire logic wait_pin_pullup_enable
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Taken request makes sequencer busy
	property p_busy; dma_req_valid && dma_req_ready |=> !dma_req_ready; endproperty
	a_busy: assert property (p_busy) else $error("busy missing");
	// Unsampled short access ends after one cycle
	property p_short;
		dma_req_valid && dma_req_ready ##2 dma_done |-> dma_cycles == 4'h1;
	endproperty
	a_short: assert property (p_short) else $error("short len");
	// Done is one pulse, sequencer idle
	property p_done; dma_done |-> dma_req_ready ##1 !dma_done; endproperty
	a_done: assert property (p_done) else $error("done pulse");
	// Access ends in bounded time
	property p_len; $fell(dma_req_ready) |-> ##[1:40] dma_done; endproperty
	a_len: assert property (p_len) else $error("no done");
	// Reported length never zero
	property p_nz; dma_done |-> dma_cycles != 4'h0; endproperty
	a_nz: assert property (p_nz) else $error("zero len");
	// Write response holds until taken
	property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
	a_bhold: assert property (p_bhold) else $error("bvalid drop");
	// No new read while data pending
	property p_rblk; s_axi_rvalid |-> !s_axi_arready; endproperty
	a_rblk: assert property (p_rblk) else $error("arready");
	// Pull-up on after reset
	property p_pu; $rose(aresetn) |-> wait_pin_pullup_enable; endproperty
	a_pu: assert property (p_pu) else $error("pullup reset");
endmodule : bwsc_checker
bind bwsc_top bwsc_checker bwsc_checker_i (.aclk, .aresetn, .dma_req_valid,
	.dma_req_ready, .dma_done, .dma_cycles, .s_axi_bvalid, .s_axi_bready,
	.s_axi_rvalid, .s_axi_arready, .wait_pin_pullup_enable);
`default_nettype wire

// File: bwsc_params.svh
// Purpose: Constants for the bus wait-state control block
// Assumes: Included by bare name after the package
// Notes: Byte address of a register is four times its index
`ifndef BWSC_PARAMS_SVH
`define BWSC_PARAMS_SVH

// Register indices as printed
`define BWSC_IDX_SAMPLE 32'h05ff_ffa4
`define BWSC_IDX_LWAIT 32'h05ff_ffa6
`define BWSC_IDX_DRAMCTL 32'h05ff_ffa8
`define BWSC_IDX_BUSCFG 32'h05ff_ffac

// Byte addresses derived from indices
`define BWSC_ADDR_SAMPLE (`BWSC_IDX_SAMPLE << 2)
`define BWSC_ADDR_LWAIT (`BWSC_IDX_LWAIT << 2)
`define BWSC_ADDR_DRAMCTL (`BWSC_IDX_DRAMCTL << 2)
`define BWSC_ADDR_BUSCFG (`BWSC_IDX_BUSCFG << 2)

// Reset values
`define BWSC_RST_SAMPLE 16'hffff
`define BWSC_RST_LWAIT 16'hf800
`define BWSC_RST_BUSCFG 16'h0000

// Field positions: sample register
`define BWSC_RD_MSB 15
`define BWSC_RD_LSB 8
`define BWSC_WR_MSB 7
`define BWSC_WR_LSB 0

// Field positions: long-wait register
`define BWSC_PU_BIT 15
`define BWSC_A02_MSB 14
`define BWSC_A02_LSB 13
`define BWSC_A6_MSB 12
`define BWSC_A6_LSB 11
`define BWSC_LW_MASK 16'hf800

// Field positions: own bus configuration register
`define BWSC_DRAM_BIT 15
`define BWSC_IOMUX_BIT 14
`define BWSC_CFG_MASK 16'hc000

// Access timing, in bus cycles
`define BWSC_CYC_SHORT 4'h1
`define BWSC_CYC_LONG 4'h2
`define BWSC_CYC_MUX 4'h5

// Areas
`define BWSC_AREA0 3'h0
`define BWSC_AREA1 3'h1
`define BWSC_AREA2 3'h2
`define BWSC_AREA6 3'h6

// AXI responses
`define BWSC_RESP_OKAY 2'h0
`define BWSC_RESP_SLVERR 2'h2

`endif

// File: bwsc_pkg.sv
// Purpose: Types for the bus wait-state control block
// Assumes: Nothing
// Notes: Constants live in bwsc_params.svh
package bwsc_pkg;

	// Access sequencer states
	typedef enum logic [1:0] {
		BWSC_IDLE,
		BWSC_COUNT,
		BWSC_EXTEND
	} bwsc_state_t;

endpackage : bwsc_pkg

// File: bwsc_top.sv
// Purpose: Wait-state settings and single-mode DMA access timing
// Assumes: One clock, synchronous active-low reset, AXI4-Lite slave
// Notes: The wait pin is active low and passes two flops first
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "bwsc_params.svh"

// Contract
// - Read-sample bit per area for DMA reads
// - Write-sample bit per area for DMA writes
// - Clear bit: areas 1,3-5,7 take one cycle
// - Set bit: two cycles plus wait extension
// - Areas 0,2,6: one plus long wait
// - Multiplex I/O: four waits plus extension always
// - Pull-up bit drives wait pin pull-up
// - Pull-up bit resets to one
// - Areas 0,2 long-wait code gives 1-4 cycles
// - Area 6 long-wait code gives 1-4 cycles
// - Both long-wait fields reset to code 11
// - Area 1 DRAM only when select bit set
module bwsc_top
	import bwsc_pkg::*;
#(
	parameter int ADDR_W = 32
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic dma_req_valid,
	output logic dma_req_ready,
	input wire logic [2:0] dma_req_area,
	input wire logic dma_req_write,
	output logic dma_done,
	output logic [3:0] dma_cycles,
	input wire logic wait_pin_n,
	output logic wait_pin_pullup_enable,
	output logic area1_dram_select
);

	// Elaboration check on address width
	if (ADDR_W < 32) begin : g_chk
		$error("ADDR_W must be at least 32");
	end

	// Decodes a byte address to a register select, one-hot
	function automatic logic [3:0] bwsc_dec(input logic [ADDR_W-1:0] a);
		logic [31:0] w;
		w = a[31:0];
		bwsc_dec[0] = (w == 32'(`BWSC_ADDR_SAMPLE));
		bwsc_dec[1] = (w == 32'(`BWSC_ADDR_LWAIT));
		bwsc_dec[2] = (w == 32'(`BWSC_ADDR_DRAMCTL));
		bwsc_dec[3] = (w == 32'(`BWSC_ADDR_BUSCFG));
	endfunction : bwsc_dec

	// Long-wait code to cycle count, code 00 is one cycle
	function automatic logic [3:0] bwsc_lw(input logic [1:0] code);
		bwsc_lw = {2'h0, code} + `BWSC_CYC_SHORT;
	endfunction : bwsc_lw

	// Software-visible registers
	logic [15:0] sample_q; // Read and write sample bits
	logic [15:0] lwait_q; // Pull-up and long-wait fields
	logic [15:0] buscfg_q; // DRAM select and multiplex enable

	// Write channel holding registers
	logic aw_have_q; // Write address held
	logic [ADDR_W-1:0] aw_addr_q; // Held write address
	logic w_have_q; // Write data held
	logic [31:0] w_data_q; // Held write data
	logic [3:0] w_strb_q; // Held byte strobes
	logic bvalid_q; // Write response pending
	logic [1:0] bresp_q; // Write response code

	// Read channel registers
	logic rvalid_q; // Read data pending
	logic [31:0] rdata_q; // Read data
	logic [1:0] rresp_q; // Read response code

	// Wait pin synchroniser, first flop feeds only the second
	logic wait_s1_q;
	logic wait_s2_q;
	logic wait_act; // Wait asserted, synchronised

	// Access sequencer
	bwsc_state_t state_q; // Sequencer state
	logic [3:0] cnt_q; // Remaining base cycles
	logic [3:0] tot_q; // Cycles elapsed
	logic smp_q; // Wait sampling on for this access
	logic done_q; // Completion pulse
	logic [3:0] cyc_q; // Last access length

	// Write path decode
	logic do_write; // Both halves held, response free
	logic [3:0] wsel; // Write register select
	logic [15:0] wmask; // Byte-lane mask of low half
	logic wmapped; // Write hits a stored register

	assign s_axi_awready = !aw_have_q;
	assign s_axi_wready = !w_have_q;
	assign do_write = aw_have_q && w_have_q && !bvalid_q;
	assign wsel = bwsc_dec(aw_addr_q);
	assign wmapped = wsel[0] || wsel[1] || wsel[3];
	assign wmask = {{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};

	// Next values of the settings registers
	logic [15:0] sample_d;
	logic [15:0] lwait_d;
	logic [15:0] buscfg_d;
	assign sample_d = (sample_q & ~wmask) | (w_data_q[15:0] & wmask);
	assign lwait_d = ((lwait_q & ~wmask) | (w_data_q[15:0] & wmask))
		& `BWSC_LW_MASK;
	assign buscfg_d = ((buscfg_q & ~wmask) | (w_data_q[15:0] & wmask))
		& `BWSC_CFG_MASK;

	// Capture write address and data in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			aw_addr_q <= '0;
			w_have_q <= 1'b0;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end else if (do_write) begin
				aw_have_q <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end else if (do_write) begin
				w_have_q <= 1'b0;
			end
		end
	end

	// Settings registers and write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sample_q <= `BWSC_RST_SAMPLE;
			lwait_q <= `BWSC_RST_LWAIT;
			buscfg_q <= `BWSC_RST_BUSCFG;
			bvalid_q <= 1'b0;
			bresp_q <= `BWSC_RESP_OKAY;
		end else begin
			if (do_write) begin
				// Store and answer
				if (wsel[0]) sample_q <= sample_d;
				if (wsel[1]) lwait_q <= lwait_d;
				if (wsel[3]) buscfg_q <= buscfg_d;
				bvalid_q <= 1'b1;
				bresp_q <= wmapped ? `BWSC_RESP_OKAY : `BWSC_RESP_SLVERR;
			end else if (s_axi_bready) begin
				// Response taken
				bvalid_q <= 1'b0;
			end
		end
	end

	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;

	// Read path decode
	logic [3:0] rsel; // Read register select
	logic [15:0] rword; // Selected register value
	logic rmapped; // Read hits a register
	assign s_axi_arready = !rvalid_q;
	assign rsel = bwsc_dec(s_axi_araddr);
	assign rmapped = rsel[0] || rsel[1] || rsel[3];
	assign rword = rsel[0] ? sample_q :
		rsel[1] ? (lwait_q & `BWSC_LW_MASK) :
		rsel[3] ? buscfg_q : 16'h0000;

	// Read data register, one cycle after the address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= `BWSC_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_q <= 1'b1;
			rdata_q <= {16'h0000, rword};
			rresp_q <= rmapped ? `BWSC_RESP_OKAY : `BWSC_RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	// Pin-facing outputs
	assign wait_pin_pullup_enable = lwait_q[`BWSC_PU_BIT];
	assign area1_dram_select = buscfg_q[`BWSC_DRAM_BIT];

	// Wait pin synchroniser
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wait_s1_q <= 1'b1;
			wait_s2_q <= 1'b1;
		end else begin
			wait_s1_q <= wait_pin_n;
			wait_s2_q <= wait_s1_q;
		end
	end
	assign wait_act = !wait_s2_q;

	// Per-access timing selection
	logic smp_bit; // Area's sample bit for the direction
	logic lw_area; // Area with long wait
	logic mux_io; // Multiplex I/O access
	logic dram_col; // DRAM column access on area 1
	logic [3:0] lw_cyc; // Long-wait cycles of the area
	logic [3:0] base_d; // Fixed cycles of the access
	logic smp_d; // Wait sampled in this access
	assign smp_bit = dma_req_write
		? sample_q[`BWSC_WR_LSB + 32'(dma_req_area)]
		: sample_q[`BWSC_RD_LSB + 32'(dma_req_area)];
	assign mux_io = (dma_req_area == `BWSC_AREA6)
		&& buscfg_q[`BWSC_IOMUX_BIT];
	assign dram_col = (dma_req_area == `BWSC_AREA1)
		&& buscfg_q[`BWSC_DRAM_BIT];
	assign lw_area = ((dma_req_area == `BWSC_AREA0)
		|| (dma_req_area == `BWSC_AREA2)
		|| (dma_req_area == `BWSC_AREA6)) && !mux_io;
	assign lw_cyc = (dma_req_area == `BWSC_AREA6)
		? bwsc_lw(lwait_q[`BWSC_A6_MSB:`BWSC_A6_LSB])
		: bwsc_lw(lwait_q[`BWSC_A02_MSB:`BWSC_A02_LSB]);
	// DRAM column and ordinary areas share short and long pitch
	assign base_d = mux_io ? `BWSC_CYC_MUX :
		lw_area ? (`BWSC_CYC_SHORT + lw_cyc) :
		(smp_bit || dram_col && smp_bit) ? `BWSC_CYC_LONG :
		`BWSC_CYC_SHORT;
	assign smp_d = mux_io || smp_bit;
	assign dma_req_ready = (state_q == BWSC_IDLE);

	// Access sequencer: count base cycles then extend on wait
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= BWSC_IDLE;
			cnt_q <= 4'h0;
			tot_q <= 4'h0;
			smp_q <= 1'b0;
			done_q <= 1'b0;
			cyc_q <= 4'h0;
		end else begin
			done_q <= 1'b0;
			unique case (state_q)
				BWSC_IDLE: begin
					// Start on request
					if (dma_req_valid) begin
						state_q <= BWSC_COUNT;
						cnt_q <= base_d;
						tot_q <= 4'h0;
						smp_q <= smp_d;
					end
				end
				BWSC_COUNT: begin
					// One base cycle elapses
					tot_q <= tot_q + 4'h1;
					cnt_q <= cnt_q - 4'h1;
					if (cnt_q == 4'h1) begin
						if (smp_q && wait_act) begin
							state_q <= BWSC_EXTEND;
						end else begin
							state_q <= BWSC_IDLE;
							done_q <= 1'b1;
							cyc_q <= tot_q + 4'h1;
						end
					end
				end
				BWSC_EXTEND: begin
					// Extra cycle while wait held, saturating count
					if (tot_q != 4'hf) tot_q <= tot_q + 4'h1;
					if (!wait_act) begin
						state_q <= BWSC_IDLE;
						done_q <= 1'b1;
						// Count this last cycle too, saturating
						cyc_q <= (tot_q == 4'hf) ? tot_q : tot_q + 4'h1;
					end
				end
			endcase
		end
	end

	assign dma_done = done_q;
	assign dma_cycles = cyc_q;

	// Protection bits carry no meaning here
	logic unused_prot;
	assign unused_prot = ^{s_axi_awprot, s_axi_arprot, w_data_q[31:16],
		w_strb_q[3:2]};

endmodule : bwsc_top
`default_nettype wire

// File: bwsc_top_tb_top.sv
// Purpose: Register and DMA timing tests
// Assumes: 50 ns clock, AXI4-Lite master tasks
// Notes: Wait lengths from the slow device model
`timescale 1ns/1ps
`default_nettype none
`include "bwsc_params.svh"
`define CHK(n, e, v) \
	tests_run++; \
	if ((v) !== (e)) begin \
		errors++; \
		$display("wrong value %s exp %h got %h", n, e, v); \
	end
module bwsc_top_tb_top;
	logic aclk = 1'b0, aresetn = 1'b0, wait_pin_n;
	logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
	logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, dma_req_ready, dma_done;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [31:0] s_axi_rdata, d;
	logic dma_req_valid = 0, dma_req_write = 0;
	logic [2:0] dma_req_area = '0;
	logic [3:0] dma_cycles, hold = '0, cy;
	logic wait_pin_pullup_enable, area1_dram_select;
	int errors = 0, tests_run = 0, cyc = 0;
	always #25 aclk = ~aclk;
	bwsc_top bwsc_top_i (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .dma_req_valid, .dma_req_ready,
		.dma_req_area, .dma_req_write, .dma_done, .dma_cycles, .wait_pin_n,
		.wait_pin_pullup_enable, .area1_dram_select);
	bwsc_wait_model bwsc_wait_model_i (.aclk, .dma_req_valid, .dma_req_ready,
		.hold, .wait_pin_n);
	// Verdict and end of run
	task close_out;
		if (errors == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : close_out
	// Bus write, response into r
	task wr(input logic [31:0] a, input logic [31:0] v);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 0;
		repeat (2) @(posedge aclk);
	endtask : wr
	// Bus read into d and r
	task rd(input logic [31:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 0;
	endtask : rd
	// One DMA access, length into cy
	task dma(input logic [2:0] ar, input logic w, input logic [3:0] h);
		@(posedge aclk);
		dma_req_area <= ar;
		dma_req_write <= w;
		hold <= h;
		dma_req_valid <= 1;
		do @(posedge aclk); while (!dma_req_ready);
		dma_req_valid <= 0;
		hold <= 4'h0;
		do @(posedge aclk); while (!dma_done);
		cy = dma_cycles;
		// Let the device release wait and the synchroniser settle
		while (!wait_pin_n) @(posedge aclk);
		repeat (2) @(posedge aclk);
	endtask : dma
	// Hang guard
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 5000) begin
			errors++;
			close_out;
		end
	end
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1;
		rd(`BWSC_ADDR_SAMPLE);
		`CHK("sample", 32'hffff, d)
		rd(`BWSC_ADDR_LWAIT);
		`CHK("lwait", 32'hf800, d)
		`CHK("pullup", 1'b1, wait_pin_pullup_enable)
		rd(`BWSC_ADDR_DRAMCTL);
		`CHK("dram ctl", `BWSC_RESP_SLVERR, r)
		wr(32'h0, 32'h1);
		`CHK("unmapped", `BWSC_RESP_SLVERR, r)
		wr(`BWSC_ADDR_LWAIT, 32'h7fff);
		rd(`BWSC_ADDR_LWAIT);
		`CHK("lwait wr", 32'h7800, d)
		`CHK("pullup off", 1'b0, wait_pin_pullup_enable)
		wr(`BWSC_ADDR_SAMPLE, 32'h0);
		for (int c = 0; c < 4; c++) begin
			wr(`BWSC_ADDR_LWAIT, 32'h8000 | (c << 13) | (c << 11));
			dma(3'h0, 0, 4'h6);
			`CHK("area0", 4'(2 + c), cy)
			dma(3'h6, 1, 4'h6);
			`CHK("area6", 4'(2 + c), cy)
		end
		dma(3'h3, 0, 4'h6);
		`CHK("area3 clr", 4'h1, cy)
		wr(`BWSC_ADDR_SAMPLE, 32'hff00);
		dma(3'h5, 1, 4'h6);
		`CHK("area5 wr", 4'h1, cy)
		dma(3'h5, 0, 4'h0);
		`CHK("area5 rd", 4'h2, cy)
		dma(3'h5, 0, 4'h6);
		`CHK("area5 ext", 1'b1, cy > 4'h2)
		wr(`BWSC_ADDR_BUSCFG, 32'hc000);
		`CHK("dram sel", 1'b1, area1_dram_select)
		wr(`BWSC_ADDR_SAMPLE, 32'h0);
		dma(3'h6, 0, 4'h0);
		`CHK("mux", 4'h5, cy)
		dma(3'h6, 0, 4'h6);
		`CHK("mux ext", 1'b1, cy > 4'h5)
		dma(3'h1, 1, 4'h6);
		`CHK("dram col", 4'h1, cy)
		close_out;
	end
endmodule : bwsc_top_tb_top
`default_nettype wire

// File: bwsc_wait_model.sv
// Purpose: Slow external device driving the wait pin
// Assumes: Pin pulled up when released
// Notes: Holds wait low while requesting with nonzero hold, then hold cycles
`timescale 1ns/1ps
`default_nettype none
module bwsc_wait_model (
	input wire logic aclk,
	input wire logic dma_req_valid,
	input wire logic dma_req_ready,
	input wire logic [3:0] hold,
	output logic wait_pin_n
);
	logic [3:0] cnt_q = 4'h0; // Remaining low cycles
	// Load on take, count down after
	always_ff @(posedge aclk) begin
		if (dma_req_valid && dma_req_ready)
			cnt_q <= hold;
		else if (cnt_q != 4'h0)
			cnt_q <= cnt_q - 4'h1;
	end
	// Released line rests at pull-up level
	assign wait_pin_n = !((dma_req_valid && hold != 4'h0) || cnt_q != 4'h0);
endmodule : bwsc_wait_model
`default_nettype wire
